// [verilog/bfcsu_pkg.sv]
// package: constants and types for the boot flash host controller
package bfcsu_pkg;
    // =====================================================================
    // flash command codes
    localparam logic [7:0] CMD_READ_ARRAY  = 8'h0_0FF;
    localparam logic [7:0] CMD_READ_SIG    = 8'h0_090;
    localparam logic [7:0] CMD_READ_STATUS = 8'h0_070;
    localparam logic [7:0] CMD_CLEAR_STAT  = 8'h0_050;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h0_020;
    localparam logic [7:0] CMD_CONFIRM     = 8'h0_0D0;
    localparam logic [7:0] CMD_SUSPEND     = 8'h0_0B0;
    localparam logic [7:0] CMD_PROG_SETUP  = 8'h0_040;
    // =====================================================================
    // status bit positions
    localparam int SR_READY   = 7;
    localparam int SR_PAUSED  = 6;
    localparam int SR_ERASEF  = 5;
    localparam int SR_PROGF   = 4;
    localparam logic [7:0] SR_USED_MASK = 8'h0_0F8;
    // =====================================================================
    // host register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h0_000;
    localparam logic [7:0] REG_ADDR   = 8'h0_004;
    localparam logic [7:0] REG_DATA   = 8'h0_008;
    localparam logic [7:0] REG_STATUS = 8'h0_00C;
    localparam logic [7:0] REG_PINS   = 8'h0_010;
    // ctrl field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_PD     = 4;
    localparam int CTRL_HV     = 5;
    localparam int CTRL_GO     = 8;
    // status field positions
    localparam int ST_BUSY = 8;
    localparam int ST_DONE = 9;
    localparam int ST_ERR  = 10;
    // =====================================================================
    // strobe timing
    localparam int T_STROBE_NS = 40;
    localparam int T_GAP_NS    = 10;
    localparam int T_READ_NS   = 120;
    localparam int T_PDREC_NS  = 480;
    localparam int CLK_NS      = 10;
    localparam int CYC_STROBE  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_GAP     = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_READ    = (T_READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_PDREC   = (T_PDREC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W       = 8;
    localparam int POLL_LIMIT  = 255;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // =====================================================================
    // host operations
    typedef enum logic [3:0] {
        OP_READ, OP_WRITE_CMD, OP_READ_STATUS, OP_CLEAR, OP_ERASE,
        OP_PROGRAM, OP_SUSPEND, OP_RESUME, OP_SIG, OP_RESET_ARRAY
    } bfcsu_op_t;
    typedef struct packed {
        logic       cs_n;
        logic       oe_n;
        logic       we_n;
        logic       pd_n;
        logic       hv_a9;
        logic [16:0] addr;
        logic [7:0] dout;
        logic       doe;
    } bfcsu_pins_t;
    typedef struct packed {
        logic       write;
        logic [7:0] data;
    } bfcsu_cyc_t;
endpackage

// [verilog/bfcsu_strobe.sv]
// module: one flash bus cycle (write or read) with timed strobes
`timescale 1ns/100ps
module bfcsu_strobe
    import bfcsu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        start,
    input  wire bfcsu_cyc_t  cyc,
    input  wire logic [7:0]  din,
    output logic             cs_n,
    output logic             oe_n,
    output logic             we_n,
    output logic             doe,
    output logic [7:0]       dout,
    output logic [7:0]       rdata,
    output logic             done
);
    typedef enum {S_IDLE, S_LOW, S_GAP} bfcsu_sst_t;
    bfcsu_sst_t       st;
    logic [CNT_W-1:0] cnt;
    logic             wr;

    // =====================================================================
    // cycle sequencing; strobes fall and rise together with cs_n so the
    // later falling edge of oe_n/cs_n re-latches status on each read
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= S_IDLE;
            cnt <= '0;
            wr <= 1'b0;
            cs_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            doe <= 1'b0;
            dout <= '0;
            rdata <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st)
                S_IDLE: begin
                    if (start) begin
                        wr <= cyc.write;
                        dout <= cyc.data;
                        doe <= cyc.write;
                        cs_n <= 1'b0;
                        we_n <= !cyc.write;
                        oe_n <= cyc.write;
                        cnt <= cyc.write ? CNT_W'(CYC_STROBE) : CNT_W'(CYC_READ);
                        st <= S_LOW;
                    end
                end
                S_LOW: begin
                    if (cnt > CNT_W'(1)) begin
                        cnt <= cnt - CNT_W'(1);
                    end else begin
                        if (!wr) begin
                            rdata <= din;
                        end
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        cs_n <= 1'b1;
                        cnt <= CNT_W'(CYC_GAP);
                        st <= S_GAP;
                    end
                end
                S_GAP: begin
                    doe <= 1'b0;
                    if (cnt > CNT_W'(1)) begin
                        cnt <= cnt - CNT_W'(1);
                    end else begin
                        done <= 1'b1;
                        st <= S_IDLE;
                    end
                end
                default: st <= S_IDLE;
            endcase
        end
    end

    // =====================================================================
    a_write_hold_data: assert property (@(posedge clk) disable iff (!resetn)
        $rose(we_n) |-> doe) else $error("data released before strobe rise");
    a_strobe_excl: assert property (@(posedge clk) disable iff (!resetn)
        !(oe_n == 1'b0 && we_n == 1'b0)) else $error("read and write strobes overlap");
    a_status_toggle: assert property (@(posedge clk) disable iff (!resetn)
        done |-> cs_n && oe_n) else $error("strobes not raised between cycles");
endmodule // bfcsu_strobe

// [verilog/bfcsu_top.sv]
// module: AHB-Lite host controller driving a parallel boot flash
// Summary of operation
// - read with select and drive low
// - FFH write returns to array read
// - 90H gives signature at 0 and 1
// - raise strobes between status reads
// - clear status after supply low
// - erase is 20H then D0H in block
// - D0H resumes a paused erase
// - 40H then address/data program write
// - check ready before failure bits
`timescale 1ns/100ps
module bfcsu_top
    import bfcsu_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RESETN,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             FL_CS_N,
    output logic             FL_OE_N,
    output logic             FL_WE_N,
    output logic             FL_PD_N,
    output logic             FL_HV_A9,
    output logic [16:0]      FL_ADDR,
    input  wire logic [7:0]  FL_DQ_I,
    output logic [7:0]       FL_DQ_O,
    output logic             FL_DQ_OE
);
    typedef enum {M_IDLE, M_C1, M_C2, M_POLL, M_PDREC} bfcsu_mst_t;

    logic             dph_valid;
    logic             dph_write;
    logic [7:0]       dph_addr;
    logic [7:0]       op;
    logic             pd;
    logic             hv;
    logic [16:0]      addr;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
    logic [7:0]       status;
    logic             busy;
    logic             done;
    logic             err;
    bfcsu_mst_t       st;
    logic [CNT_W-1:0] cnt;
    logic             start;
    bfcsu_cyc_t       cyc;
    logic             s_done;
    logic [7:0]       s_rdata;
    logic             go;
    logic             s_cs_n;

    function automatic bfcsu_cyc_t wcyc(input logic [7:0] d);
        wcyc.write = 1'b1;
        wcyc.data = d;
    endfunction
    function automatic logic [7:0] mask_sr(input logic [7:0] d);
        mask_sr = d & SR_USED_MASK;
    endfunction

    // =====================================================================
    // AHB-Lite slave: zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign go = dph_valid && dph_write && dph_addr == REG_CTRL && HWDATA[CTRL_GO];

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            dph_valid <= 1'b0;
            dph_write <= 1'b0;
            dph_addr <= '0;
        end else begin
            dph_valid <= HSEL && HREADY && HTRANS[1];
            dph_write <= HWRITE;
            dph_addr <= HADDR[7:0];
        end
    end

    always_comb begin
        HRDATA = RESET_WORD;
        case (dph_addr)
            REG_CTRL:   HRDATA = {26'd0, hv, pd, op[3:0]};
            REG_ADDR:   HRDATA = {15'd0, addr};
            REG_DATA:   HRDATA = {24'd0, rdata};
            REG_STATUS: HRDATA = {21'd0, err, done, busy, status};
            REG_PINS:   HRDATA = {27'd0, FL_PD_N, FL_HV_A9, FL_CS_N, FL_OE_N, FL_WE_N};
            default:    HRDATA = RESET_WORD;
        endcase
    end

    // software configuration registers
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            op <= '0;
            pd <= 1'b0;
            hv <= 1'b0;
            addr <= '0;
            wdata <= '0;
        end else if (dph_valid && dph_write) begin
            case (dph_addr)
                REG_CTRL: begin
                    if (!busy) begin
                        op <= {4'd0, HWDATA[CTRL_OP_LSB +: 4]};
                        hv <= HWDATA[CTRL_HV];
                    end
                    pd <= HWDATA[CTRL_PD];
                end
                REG_ADDR: addr <= HWDATA[16:0];
                REG_DATA: wdata <= HWDATA[7:0];
                default: ;
            endcase
        end
    end

    // =====================================================================
    // powerdown pin: low puts the device into deep powerdown and aborts it
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            FL_PD_N <= 1'b0;
        end else begin
            FL_PD_N <= !pd;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            FL_HV_A9 <= 1'b0;
            FL_ADDR <= '0;
        end else begin
            FL_HV_A9 <= hv;
            FL_ADDR <= addr;
        end
    end

    // =====================================================================
    // operation sequencer
    always_comb begin
        start = 1'b0;
        cyc = wcyc(CMD_READ_ARRAY);
        case (st)
            M_C1: begin
                start = 1'b1;
                case (bfcsu_op_t'(op[3:0]))
                    OP_READ:        cyc = '{write: 1'b0, data: 8'h0_000};
                    OP_WRITE_CMD:   cyc = wcyc(wdata);
                    OP_READ_STATUS: cyc = wcyc(CMD_READ_STATUS);
                    OP_CLEAR:       cyc = wcyc(CMD_CLEAR_STAT);
                    OP_ERASE:       cyc = wcyc(CMD_ERASE_SETUP);
                    OP_PROGRAM:     cyc = wcyc(CMD_PROG_SETUP);
                    OP_SUSPEND:     cyc = wcyc(CMD_SUSPEND);
                    OP_RESUME:      cyc = wcyc(CMD_CONFIRM);
                    OP_SIG:         cyc = wcyc(CMD_READ_SIG);
                    default:        cyc = wcyc(CMD_READ_ARRAY);
                endcase
            end
            M_C2: begin
                start = 1'b1;
                case (bfcsu_op_t'(op[3:0]))
                    OP_ERASE:   cyc = wcyc(CMD_CONFIRM);
                    OP_PROGRAM: cyc = wcyc(wdata);
                    default:    cyc = '{write: 1'b0, data: 8'h0_000};
                endcase
            end
            M_POLL: begin
                start = 1'b1;
                cyc = '{write: 1'b0, data: 8'h0_000};
            end
            default: ;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            st <= M_IDLE;
            busy <= 1'b0;
            done <= 1'b0;
            err <= 1'b0;
            status <= '0;
            rdata <= '0;
            cnt <= '0;
        end else begin
            case (st)
                M_IDLE: begin
                    if (!FL_PD_N) begin
                        cnt <= CNT_W'(CYC_PDREC);
                        st <= M_PDREC;
                    end else if (go) begin
                        busy <= 1'b1;
                        done <= 1'b0;
                        err <= 1'b0;
                        st <= M_C1;
                    end
                end
                M_PDREC: begin
                    // the device resumes in array read after powerdown exit
                    if (!FL_PD_N) begin
                        cnt <= CNT_W'(CYC_PDREC);
                    end else if (cnt > CNT_W'(1)) begin
                        cnt <= cnt - CNT_W'(1);
                    end else begin
                        st <= M_IDLE;
                    end
                end
                M_C1: begin
                    if (s_done) begin
                        if (bfcsu_op_t'(op[3:0]) == OP_READ) begin
                            rdata <= s_rdata;
                            busy <= 1'b0;
                            done <= 1'b1;
                            st <= M_IDLE;
                        end else begin
                            st <= M_C2;
                        end
                    end else begin
                        st <= M_C1;
                    end
                end
                M_C2: begin
                    if (s_done) begin
                        cnt <= CNT_W'(POLL_LIMIT);
                        st <= M_POLL;
                        if (bfcsu_op_t'(op[3:0]) == OP_SIG || bfcsu_op_t'(op[3:0]) == OP_READ_STATUS
                            || bfcsu_op_t'(op[3:0]) == OP_WRITE_CMD
                            || bfcsu_op_t'(op[3:0]) == OP_RESET_ARRAY) begin
                            rdata <= s_rdata;
                            busy <= 1'b0;
                            done <= 1'b1;
                            st <= M_IDLE;
                        end
                    end
                end
                M_POLL: begin
                    if (s_done) begin
                        rdata <= s_rdata;
                        status <= mask_sr(s_rdata);
                        // ready must be seen before the fail bits count
                        if (s_rdata[SR_READY]) begin
                            err <= s_rdata[SR_ERASEF] | s_rdata[SR_PROGF];
                            busy <= 1'b0;
                            done <= 1'b1;
                            st <= M_IDLE;
                        end else if (cnt == '0) begin
                            err <= 1'b1;
                            busy <= 1'b0;
                            st <= M_IDLE;
                        end else begin
                            cnt <= cnt - CNT_W'(1);
                        end
                    end
                    if (!FL_PD_N) begin
                        busy <= 1'b0;
                        err <= 1'b1;
                        st <= M_IDLE;
                    end
                end
                default: st <= M_IDLE;
            endcase
        end
    end

    // =====================================================================
    bfcsu_strobe u_strobe (
        .clk    (CLK_SYS),
        .resetn (RESETN),
        .start  (start && !s_done && FL_PD_N),
        .cyc    (cyc),
        .din    (FL_DQ_I),
        .cs_n   (s_cs_n),
        .oe_n   (FL_OE_N),
        .we_n   (FL_WE_N),
        .doe    (FL_DQ_OE),
        .dout   (FL_DQ_O),
        .rdata  (s_rdata),
        .done   (s_done)
    );
    assign FL_CS_N = s_cs_n;

    // =====================================================================
    a_pd_no_strobe: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (!FL_PD_N && st == M_IDLE) |=> FL_CS_N) else $error("access during powerdown");
    a_poll_ready: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (st == M_POLL && s_done && s_rdata[SR_READY]) |=> done && !busy)
        else $error("ready status not completed");
    a_status_mask: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        status[2:0] == 3'd0) else $error("reserved status bits kept");
    a_go_busy: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (st == M_IDLE && go && FL_PD_N) |=> busy ##1 !FL_CS_N)
        else $error("operation not started");
    a_pd_wait: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $rose(FL_PD_N) |-> FL_CS_N [*8]) else $error("powerdown recovery short");
    c_erase: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
        st == M_POLL && bfcsu_op_t'(op[3:0]) == OP_ERASE && s_done);
    c_prog: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
        st == M_POLL && bfcsu_op_t'(op[3:0]) == OP_PROGRAM && s_done && s_rdata[SR_READY]);
    c_read: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
        st == M_C1 && s_done && bfcsu_op_t'(op[3:0]) == OP_READ);
endmodule // bfcsu_top

// [testbench/bfcsu_flash_model.sv]
// behavioural model of the parallel boot flash seen by the controller
`timescale 1ns/100ps
module bfcsu_flash_model #(
    parameter logic [7:0] MFG_CODE   = 8'h3C, // arbitrary maker code
    parameter logic [7:0] DEV_CODE   = 8'hA7, // arbitrary device code
    parameter int         T_PROG_NS  = 300,
    parameter int         T_ERASE_NS = 3000
) (
    input  wire logic        cs_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        pd_n,
    input  wire logic        hv_a9,
    input  wire logic        vpp_low,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  din,
    output logic [7:0]       dq
);
    // =====================================================================
    // state: only a 256-byte window of the array is kept, indexed by addr[7:0]
    logic [7:0] mem [0:255];
    logic [7:0] sr, sr_lat, last, pword, paddr;
    logic [1:0] mode;
    logic       setup_e, setup_p, busy_p, erasing, paused, sreq, wsel;
    int         remain;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        {mode, setup_e, setup_p, busy_p, erasing, paused, sreq, wsel} = '0;
        sr = 8'h80;
        sr_lat = 8'h80;
        last = 8'h00;
        remain = 0;
    end
    // =====================================================================
    // abort: array data left unchanged, mode back to array read
    always @(negedge pd_n) begin
        {mode, setup_e, setup_p, busy_p, erasing, paused, sreq} = '0;
        sr[7:6] = 2'b10;
    end
    // =====================================================================
    // command decode on the rising write strobe
    // select is judged at the falling strobe: select and strobe may rise together
    always @(negedge we_n or negedge cs_n) wsel = !we_n && !cs_n;
    always @(posedge we_n) if (wsel && pd_n) begin
        if (setup_p) begin
            setup_p = 1'b0;
            mode = 2'd2;
            if (vpp_low) sr[4:3] = 2'b11;
            else begin
                busy_p = 1'b1;
                sr[7] = 1'b0;
                pword = din;
                paddr = addr[7:0];
                remain = T_PROG_NS;
            end
        end else if (setup_e) begin
            setup_e = 1'b0;
            mode = 2'd2;
            if (din !== 8'hD0) sr[5:4] = 2'b11;
            else if (vpp_low) sr[5:3] = 3'b101;
            else begin
                erasing = 1'b1;
                sr[7] = 1'b0;
                remain = T_ERASE_NS;
            end
        end else if (busy_p) begin
            if (din == 8'h70) mode = 2'd2;
        end else begin
            case (din)
                8'hFF: mode = 2'd0;
                8'h90: mode = 2'd1;
                8'h70: mode = 2'd2;
                8'h50: sr[5:3] = 3'b000;
                8'h20: setup_e = 1'b1;
                8'h40: setup_p = 1'b1;
                8'hB0: if (erasing) begin
                    sreq = 1'b1;
                    mode = 2'd2;
                end
                8'hD0: if (paused) begin
                    paused = 1'b0;
                    sr[7:6] = 2'b00;
                    mode = 2'd2;
                end
                default: ;
            endcase
        end
    end
    // =====================================================================
    // write sequencer time base; suspension only happens on a tick
    always #10 if (busy_p || (erasing && !paused)) begin
        remain = remain - 10;
        if (erasing && sreq) begin
            paused = 1'b1;
            sreq = 1'b0;
            sr[7:6] = 2'b11;
        end else if (remain <= 0) begin
            sr[7] = 1'b1;
            if (busy_p) mem[paddr] = mem[paddr] & pword;
            else foreach (mem[i]) mem[i] = 8'hFF;
            busy_p = 1'b0;
            erasing = 1'b0;
        end
    end
    // =====================================================================
    // read path: status frozen at the later falling edge of select/drive
    always @(negedge oe_n or negedge cs_n) if (!oe_n && !cs_n) sr_lat = sr;
    wire       drive = !cs_n && !oe_n && pd_n;
    wire [7:0] val   = (hv_a9 || mode == 2'd1) ? (addr[0] ? DEV_CODE : MFG_CODE)
                     : (mode == 2'd2) ? sr_lat : mem[addr[7:0]];
    always @(drive or val) if (drive) last = val;
    // a released bus shows the inverse of the last value, not a stale copy
    assign dq = drive ? val : ~last;
endmodule // bfcsu_flash_model

// [testbench/tb.sv]
// self-checking testbench of the boot flash host controller
`timescale 1ns/100ps
module tb;
    import bfcsu_pkg::*;
    logic        clk_sys, resetn, hsel, hwrite, vpp_low;
    logic [31:0] haddr, hwdata, hrdata, st, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, cs_n, oe_n, we_n, pd_n, hv, dq_oe;
    logic [16:0] fl_addr;
    logic [7:0]  dq_o, fl_dq, model_dq;
    int          errors, comparisons;
    // pin level: the controller's data wins while its driver is on, else the model's output
    assign fl_dq = dq_oe ? dq_o : model_dq;
    bfcsu_top u_dut (.CLK_SYS(clk_sys), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .FL_CS_N(cs_n), .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_PD_N(pd_n), .FL_HV_A9(hv),
        .FL_ADDR(fl_addr), .FL_DQ_I(fl_dq), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe));
    bfcsu_flash_model u_flash (.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .pd_n(pd_n),
        .hv_a9(hv), .vpp_low(vpp_low), .addr(fl_addr), .din(fl_dq), .dq(model_dq));
    // =====================================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic run_op(input logic [3:0] op, input logic [16:0] a, input logic [7:0] d,
                          input logic h);
        int n;
        bus(1'b1, 32'(REG_ADDR), 32'(a), rd);
        bus(1'b1, 32'(REG_DATA), 32'(d), rd);
        bus(1'b1, 32'(REG_CTRL), 32'h0000_0100 | (32'(h) << CTRL_HV) | 32'(op), rd);
        n = 0;
        st = 32'h0000_0000;
        while (st[ST_DONE] !== 1'b1 && n < 2000) begin
            bus(1'b0, 32'(REG_STATUS), 32'h0000_0000, st);
            n++;
        end
        if (st[ST_DONE] !== 1'b1) errors++;
    endtask
    task automatic read_at(input logic [3:0] op, input logic [16:0] a, input logic h);
        run_op(op, a, 8'h00, h);
        bus(1'b0, 32'(REG_DATA), 32'h0000_0000, rd);
    endtask
    // =====================================================================
    // scenarios
    task automatic t_reset;
        bus(1'b0, 32'(REG_PINS), 32'h0000_0000, rd);
        chk(rd, 32'h0000_0017);
        bus(1'b0, 32'h0000_0020, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        read_at(4'd0, 17'h0_0005, 1'b0);
        chk(rd, 32'h0000_00FF);
    endtask
    task automatic t_sig;
        read_at(4'd8, 17'h0_0000, 1'b0);
        chk(rd, 32'(u_flash.MFG_CODE));
        read_at(4'd8, 17'h0_0001, 1'b0);
        chk(rd, 32'(u_flash.DEV_CODE));
        read_at(4'd9, 17'h0_0001, 1'b0);
        chk(rd, 32'h0000_00FF);
        read_at(4'd0, 17'h0_0001, 1'b1);
        chk(rd, 32'(u_flash.DEV_CODE));
    endtask
    task automatic t_prog;
        run_op(4'd5, 17'h0_0010, 8'h33, 1'b0);
        chk(st[10:0], 32'h0000_0280);
        read_at(4'd9, 17'h0_0010, 1'b0);
        chk(rd, 32'h0000_0033);
    endtask
    task automatic t_fail;
        vpp_low <= 1'b1;
        run_op(4'd4, 17'h0_0020, 8'h00, 1'b0);
        chk(st[10:0], 32'h0000_06A8);
        vpp_low <= 1'b0;
        run_op(4'd1, 17'h0_0020, 8'h20, 1'b0);
        run_op(4'd1, 17'h0_0020, 8'hFF, 1'b0);
        read_at(4'd2, 17'h0_0000, 1'b0);
        chk(rd, 32'h0000_00B8);
        run_op(4'd3, 17'h0_0000, 8'h00, 1'b0);
        chk(st[7:0], 32'h0000_0080);
    endtask
    task automatic t_suspend;
        run_op(4'd1, 17'h0_0030, 8'h20, 1'b0);
        run_op(4'd1, 17'h0_0030, 8'hD0, 1'b0);
        run_op(4'd6, 17'h0_0000, 8'h00, 1'b0);
        chk(st[7:0], 32'h0000_00C0);
        read_at(4'd9, 17'h0_0010, 1'b0);
        chk(rd, 32'h0000_0033);
        run_op(4'd7, 17'h0_0000, 8'h00, 1'b0);
        chk(st[10:0], 32'h0000_0280);
        read_at(4'd9, 17'h0_0010, 1'b0);
        chk(rd, 32'h0000_00FF);
    endtask
    task automatic t_pd;
        run_op(4'd2, 17'h0_0000, 8'h00, 1'b0);
        bus(1'b1, 32'(REG_CTRL), 32'h0000_0010, rd);
        repeat (3) @(posedge clk_sys);
        chk(32'(pd_n), 32'h0000_0000);
        bus(1'b1, 32'(REG_CTRL), 32'h0000_0000, rd);
        repeat (60) @(posedge clk_sys);
        read_at(4'd0, 17'h0_0005, 1'b0);
        chk(rd, 32'h0000_00FF);
    endtask
    task automatic complete_run;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // =====================================================================
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        {resetn, hsel, hwrite, vpp_low, htrans} = '0;
        {haddr, hwdata} = '0;
        hsize = 3'b010;
        errors = 0;
        comparisons = 0;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (60) @(posedge clk_sys);
        t_reset();
        t_sig();
        t_prog();
        t_fail();
        t_suspend();
        t_pd();
        complete_run();
    end
    // watchdog well beyond the longest expected run
    initial begin
        #800000;
        errors++;
        complete_run();
    end
endmodule // tb
